// *** design/simd_fp_exc_pkg.sv ***
// Package with constants and types for the SIMD floating-point exception unit.
package simd_fp_exc_pkg;

  localparam int          NUM_CLASS   = 6;
  localparam int          NUM_ELEM    = 4;
  localparam int          ELEM_WIDTH  = 32;
  localparam int          RES_WIDTH   = NUM_ELEM * ELEM_WIDTH;

  // Bit positions of the exception classes inside a flag or mask field.
  localparam int          CLS_INVALID = 0;
  localparam int          CLS_DENORM  = 1;
  localparam int          CLS_DIVZERO = 2;
  localparam int          CLS_OVERFLW = 3;
  localparam int          CLS_UNDERFL = 4;
  localparam int          CLS_INEXACT = 5;
  localparam logic [5:0]  PRE_CLASSES  = 6'h07;
  localparam logic [5:0]  POST_CLASSES = 6'h38;

  localparam logic [7:0]  XF_VECTOR   = 8'h13;

  // APB register byte addresses.
  localparam logic [11:0] ADDR_CTRL_STATUS = 12'h000;
  localparam logic [11:0] ADDR_INT_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_INT_MASK    = 12'h008;
  localparam logic [11:0] ADDR_UNIT_STATE  = 12'h00C;

  // Field positions of the control/status register.
  localparam int          CS_FLAGS_LSB = 0;
  localparam int          CS_MASK_LSB  = 8;
  localparam int          CS_DAZ_BIT   = 16;
  localparam int          CS_FTZ_BIT   = 17;

  // Field positions of the unit state register.
  localparam int          US_STATE_LSB = 0;
  localparam int          US_CAUSE_LSB = 8;
  localparam int          US_FAULT_BIT = 16;

  // Interrupt status bits.
  localparam int          IRQ_FAULT  = 0;
  localparam int          IRQ_TRAP   = 1;
  localparam int          IRQ_MASKED = 2;
  localparam int          IRQ_BITS   = 3;

  localparam logic [5:0]  RST_FLAGS  = 6'h00;
  localparam logic [5:0]  RST_MASK   = 6'h3F;
  localparam logic [2:0]  RST_INTMSK = 3'h0;

  localparam logic [11:0] NXT_ADDR_STEP = 12'h004;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SIGNAL = 2'b01,
    ST_ENTRY  = 2'b11
  } xf_state_t;

endpackage

// *** design/simd_fp_flag_merge.sv ***
// Merges per-element exception flags of one instruction into one class vector.
`timescale 1ns/1ps
module simd_fp_flag_merge
  import simd_fp_exc_pkg::*;
(
  input  wire logic [NUM_ELEM*NUM_CLASS-1:0] elem_flags,  // Flags of each element
  input  wire logic                          packed_op,   // Packed instruction
  output logic      [NUM_CLASS-1:0]          merged       // Merged class flags
);

  logic [NUM_CLASS-1:0] partial [NUM_ELEM];

  // Scalar operations only look at element zero; packed ones OR every element.
  genvar g;
  generate
    for (g = 0; g < NUM_ELEM; g++)
    begin : g_elem
      if (g == 0)
      begin : g_first
        assign partial[g] = elem_flags[NUM_CLASS-1:0];
      end
      else
      begin : g_rest
        assign partial[g] = partial[g-1] |
          (packed_op ? elem_flags[g*NUM_CLASS +: NUM_CLASS] : {NUM_CLASS{1'b0}});
      end
    end
  endgenerate

  // Only the class survives the merge, never the element position.
  assign merged = partial[NUM_ELEM-1];

endmodule

// *** design/simd_fp_exception_unit.sv ***
// Exception reporting unit for packed and scalar SIMD floating-point instructions.
`timescale 1ns/1ps
module simd_fp_exception_unit
  import simd_fp_exc_pkg::*;
(
  input  wire logic                          CLOCK,        // Core clock
  input  wire logic                          RST,          // Asynchronous reset
  input  wire logic                          CE,           // Clock enable
  input  wire logic                          PSEL,         // APB select
  input  wire logic                          PENABLE,      // APB enable
  input  wire logic                          PWRITE,       // APB write
  input  wire logic [11:0]                   PADDR,        // APB address
  input  wire logic [31:0]                   PWDATA,       // APB write data
  output logic      [31:0]                   PRDATA,       // APB read data
  output logic                               PREADY,       // APB ready
  output logic                               PSLVERR,      // APB error
  input  wire logic                          INSTR_VALID,  // Instruction completes
  output logic                               INSTR_READY,  // Unit takes instruction
  input  wire logic                          INSTR_PACKED, // Packed operation
  input  wire logic [NUM_ELEM*NUM_CLASS-1:0] ELEM_FLAGS,   // Raised flags per element
  input  wire logic [RES_WIDTH-1:0]          RESULT_IN,    // Computed or default result
  output logic      [RES_WIDTH-1:0]          RESULT_OUT,   // Result to writeback
  output logic                               RESULT_VALID, // Result write pulse
  output logic                               DAZ_MODE,     // Denormals as zero
  output logic                               FTZ_MODE,     // Flush to zero
  output logic                               IEEE_STRICT,  // Full IEEE 754 mode
  output logic                               EXC_REQ,      // Exception request
  output logic      [7:0]                    EXC_VECTOR,   // Exception vector
  output logic                               EXC_FAULT,    // Request is a fault
  output logic      [NUM_CLASS-1:0]          EXC_CAUSE,    // Unmasked classes raised
  input  wire logic                          EXC_ACK,      // Dispatch took request
  input  wire logic                          GATE_INTR,    // Entry via interrupt gate
  output logic                               IF_CLEAR,     // Clear interrupt enable
  output logic                               IRQ           // Unit interrupt
);

  typedef struct packed {
    xf_state_t            state;
    logic [NUM_CLASS-1:0] flags;
    logic [NUM_CLASS-1:0] mask;
    logic                 daz;
    logic                 ftz;
    logic [IRQ_BITS-1:0]  int_sts;
    logic [IRQ_BITS-1:0]  int_msk;
    logic                 exc_fault;
    logic [NUM_CLASS-1:0] exc_cause;
    logic                 if_clear;
    logic [RES_WIDTH-1:0] res;
    logic                 res_vld;
    logic [31:0]          prdata;
  } unit_state_t;

  unit_state_t          state_ff;
  unit_state_t          nxt_state;
  logic [NUM_CLASS-1:0] raised;
  logic [NUM_CLASS-1:0] pre_raised;
  logic [NUM_CLASS-1:0] post_raised;
  logic [NUM_CLASS-1:0] pre_unmasked;
  logic [NUM_CLASS-1:0] post_unmasked;
  logic [NUM_CLASS-1:0] post_cand;
  logic                 fault_hit;
  logic                 take_instr;
  logic                 wr_access;
  logic                 rd_setup;
  logic                 addr_hit;
  logic [31:0]          rd_value;
  logic [NUM_CLASS-1:0] wr_flags;
  logic [IRQ_BITS-1:0]  irq_set;
  logic [IRQ_BITS-1:0]  irq_clr;
  logic                 sel_ctrl;
  logic                 sel_ists;
  logic                 sel_imsk;
  logic                 sel_ustate;

  simd_fp_flag_merge u_merge (
    .elem_flags (ELEM_FLAGS),
    .packed_op  (INSTR_PACKED),
    .merged     (raised)
  );

  // Each class is sorted into a fault or a trap and held against its own mask bit.
  genvar c;
  generate
    for (c = 0; c < NUM_CLASS; c++)
    begin : g_class
      assign pre_raised[c]   = raised[c] & PRE_CLASSES[c];
      assign post_raised[c]  = raised[c] & POST_CLASSES[c];
      // Only flags raised by this instruction can trap; old sticky flags never do.
      assign pre_unmasked[c] = pre_raised[c] & ~state_ff.mask[c];
      assign post_cand[c]    = post_raised[c] & ~state_ff.mask[c];
    end
  endgenerate

  // An unmasked fault means the arithmetic never ran, so no trap may be reported.
  assign fault_hit     = |pre_unmasked;
  assign post_unmasked = fault_hit ? {NUM_CLASS{1'b0}} : post_cand;

  // New instructions stall while a reported exception awaits dispatch.
  assign INSTR_READY = (state_ff.state == ST_IDLE);
  assign take_instr  = CE && INSTR_VALID && INSTR_READY;

  assign wr_access = PSEL && PENABLE && PWRITE;
  assign rd_setup  = PSEL && !PENABLE && !PWRITE;

  // One decode serves reads and writes alike, so both always agree on the map.
  always_comb
  begin
    sel_ctrl   = 1'b0;
    sel_ists   = 1'b0;
    sel_imsk   = 1'b0;
    sel_ustate = 1'b0;
    if (PADDR == ADDR_CTRL_STATUS)
    begin
      sel_ctrl = 1'b1;
    end
    else if (PADDR == ADDR_INT_STATUS)
    begin
      sel_ists = 1'b1;
    end
    else if (PADDR == ADDR_INT_MASK)
    begin
      sel_imsk = 1'b1;
    end
    else if (PADDR == ADDR_UNIT_STATE)
    begin
      sel_ustate = 1'b1;
    end
  end

  assign addr_hit = sel_ctrl || sel_ists || sel_imsk || sel_ustate;

  always_comb
  begin
    rd_value = 32'h0000_0000;
    if (sel_ctrl)
    begin
      rd_value[CS_FLAGS_LSB +: NUM_CLASS] = state_ff.flags;
      rd_value[CS_MASK_LSB +: NUM_CLASS]  = state_ff.mask;
      rd_value[CS_DAZ_BIT]                = state_ff.daz;
      rd_value[CS_FTZ_BIT]                = state_ff.ftz;
    end
    else if (sel_ists)
    begin
      rd_value[IRQ_BITS-1:0] = state_ff.int_sts;
    end
    else if (sel_imsk)
    begin
      rd_value[IRQ_BITS-1:0] = state_ff.int_msk;
    end
    else if (sel_ustate)
    begin
      rd_value[US_STATE_LSB +: 2]         = state_ff.state;
      rd_value[US_CAUSE_LSB +: NUM_CLASS] = state_ff.exc_cause;
      rd_value[US_FAULT_BIT]              = state_ff.exc_fault;
    end
  end

  always_comb
  begin
    nxt_state = state_ff;
    wr_flags  = state_ff.flags;
    irq_set   = '0;
    irq_clr   = '0;
    nxt_state.res_vld  = 1'b0;
    nxt_state.if_clear = 1'b0;

    if (rd_setup)
    begin
      nxt_state.prdata = rd_value;
    end

    if (wr_access)
    begin
      if (sel_ctrl)
      begin
        wr_flags       = PWDATA[CS_FLAGS_LSB +: NUM_CLASS];
        nxt_state.mask = PWDATA[CS_MASK_LSB +: NUM_CLASS];
        nxt_state.daz  = PWDATA[CS_DAZ_BIT];
        nxt_state.ftz  = PWDATA[CS_FTZ_BIT];
      end
      else if (sel_ists)
      begin
        irq_clr = PWDATA[IRQ_BITS-1:0];
      end
      else if (sel_imsk)
      begin
        nxt_state.int_msk = PWDATA[IRQ_BITS-1:0];
      end
    end

    nxt_state.flags = wr_flags;

    case (state_ff.state)
      ST_IDLE:
      begin
        if (take_instr)
        begin
          if (fault_hit)
          begin
            // A fault leaves the instruction uncomputed, so only pre flags are kept.
            nxt_state.flags     = wr_flags | pre_raised;
            nxt_state.exc_fault = 1'b1;
            nxt_state.exc_cause = pre_unmasked;
            nxt_state.state     = ST_SIGNAL;
            irq_set[IRQ_FAULT]  = 1'b1;
          end
          else if (|post_unmasked)
          begin
            nxt_state.flags     = wr_flags | raised;
            nxt_state.exc_fault = 1'b0;
            nxt_state.exc_cause = post_unmasked;
            nxt_state.state     = ST_SIGNAL;
            irq_set[IRQ_TRAP]   = 1'b1;
          end
          else
          begin
            nxt_state.flags     = wr_flags | raised;
            nxt_state.res       = RESULT_IN;
            nxt_state.res_vld   = 1'b1;
            irq_set[IRQ_MASKED] = |raised;
          end
        end
      end
      ST_SIGNAL:
      begin
        if (EXC_ACK)
        begin
          nxt_state.if_clear = GATE_INTR;
          nxt_state.state    = ST_ENTRY;
        end
      end
      ST_ENTRY:
      begin
        // Sticky flags are left alone on entry.
        nxt_state.exc_cause = '0;
        nxt_state.exc_fault = 1'b0;
        nxt_state.state     = ST_IDLE;
      end
      default:
      begin
        nxt_state.state = ST_IDLE;
      end
    endcase

    // A new event wins over a write-one-to-clear in the same cycle.
    nxt_state.int_sts = (state_ff.int_sts & ~irq_clr) | irq_set;
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      state_ff.state     <= ST_IDLE;
      state_ff.flags     <= RST_FLAGS;
      state_ff.mask      <= RST_MASK;
      state_ff.daz       <= 1'b0;
      state_ff.ftz       <= 1'b0;
      state_ff.int_sts   <= '0;
      state_ff.int_msk   <= RST_INTMSK;
      state_ff.exc_fault <= 1'b0;
      state_ff.exc_cause <= '0;
      state_ff.if_clear  <= 1'b0;
      state_ff.res       <= '0;
      state_ff.res_vld   <= 1'b0;
      state_ff.prdata    <= '0;
    end
    else if (CE)
    begin
      state_ff <= nxt_state;
    end
  end

  assign PRDATA       = state_ff.prdata;
  assign PREADY       = 1'b1;
  assign PSLVERR      = PSEL && PENABLE && !addr_hit;
  assign RESULT_OUT   = state_ff.res;
  assign RESULT_VALID = state_ff.res_vld;
  assign DAZ_MODE     = state_ff.daz;
  assign FTZ_MODE     = state_ff.ftz;
  assign IEEE_STRICT  = !state_ff.daz && !state_ff.ftz;
  assign EXC_REQ      = (state_ff.state == ST_SIGNAL);
  assign EXC_VECTOR   = XF_VECTOR;
  assign EXC_FAULT    = state_ff.exc_fault;
  assign EXC_CAUSE    = state_ff.exc_cause;
  assign IF_CLEAR     = state_ff.if_clear;
  assign IRQ          = |(state_ff.int_sts & state_ff.int_msk);

endmodule

// *** sim/simd_fp_exception_unit_chk.sv ***
// Concurrent checks on the ports of the SIMD floating-point exception unit.
`timescale 1ns/1ps
module simd_fp_exception_unit_chk
  import simd_fp_exc_pkg::*;
(
  input wire logic           CLOCK,       // Core clock
  input wire logic           RST,         // Reset
  input wire logic           CE,          // Clock enable
  input wire logic           INSTR_VALID, // Instruction valid
  input wire logic           INSTR_READY, // Instruction ready
  input wire logic [23:0]    ELEM_FLAGS,  // Element flags
  input wire logic [127:0]   RESULT_IN,   // Result in
  input wire logic [127:0]   RESULT_OUT,  // Result out
  input wire logic           RESULT_VALID, // Result pulse
  input wire logic           DAZ_MODE,    // Denormals as zero
  input wire logic           FTZ_MODE,    // Flush to zero
  input wire logic           IEEE_STRICT, // Strict mode
  input wire logic           EXC_REQ,     // Request
  input wire logic [7:0]     EXC_VECTOR,  // Vector
  input wire logic           EXC_FAULT,   // Fault kind
  input wire logic [5:0]     EXC_CAUSE,   // Cause
  input wire logic           EXC_ACK,     // Acknowledge
  input wire logic           GATE_INTR,   // Gate kind
  input wire logic           IF_CLEAR     // Clear pulse
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  logic take;
  assign take = INSTR_VALID && INSTR_READY && CE;
  vec_fixed_a: assert property (EXC_VECTOR == XF_VECTOR)
    else $error("wrong exception vector");
  clean_pass_a: assert property (take && ELEM_FLAGS == '0 |=>
    RESULT_VALID && !EXC_REQ && RESULT_OUT == $past(RESULT_IN)) else $error("no clean result");
  no_result_a: assert property (EXC_REQ |-> !RESULT_VALID)
    else $error("result during exception");
  req_origin_a: assert property ($rose(EXC_REQ) |-> $past(take))
    else $error("request without instruction");
  req_hold_a: assert property (EXC_REQ && !EXC_ACK && CE |=> EXC_REQ)
    else $error("request dropped early");
  stall_a: assert property (EXC_REQ |-> !INSTR_READY)
    else $error("ready during exception");
  gate_clear_a: assert property (EXC_REQ && EXC_ACK && GATE_INTR && CE |=>
    IF_CLEAR && !EXC_REQ) else $error("no interrupt flag clear");
  fault_first_a: assert property (EXC_REQ && EXC_FAULT |->
    EXC_CAUSE != 0 && (EXC_CAUSE & ~PRE_CLASSES) == 0) else $error("bad fault cause");
  trap_post_a: assert property (EXC_REQ && !EXC_FAULT |->
    EXC_CAUSE != 0 && (EXC_CAUSE & ~POST_CLASSES) == 0) else $error("bad trap cause");
  ieee_mode_a: assert property (IEEE_STRICT == (!DAZ_MODE && !FTZ_MODE))
    else $error("wrong strict mode");
  cover property (EXC_REQ && !EXC_FAULT);
  cover property (EXC_REQ && EXC_FAULT);
  cover property (IF_CLEAR);
endmodule

bind simd_fp_exception_unit simd_fp_exception_unit_chk chk_i (
  .CLOCK(CLOCK), .RST(RST), .CE(CE), .INSTR_VALID(INSTR_VALID),
  .INSTR_READY(INSTR_READY), .ELEM_FLAGS(ELEM_FLAGS), .RESULT_IN(RESULT_IN),
  .RESULT_OUT(RESULT_OUT), .RESULT_VALID(RESULT_VALID), .DAZ_MODE(DAZ_MODE),
  .FTZ_MODE(FTZ_MODE), .IEEE_STRICT(IEEE_STRICT), .EXC_REQ(EXC_REQ),
  .EXC_VECTOR(EXC_VECTOR), .EXC_FAULT(EXC_FAULT), .EXC_CAUSE(EXC_CAUSE),
  .EXC_ACK(EXC_ACK), .GATE_INTR(GATE_INTR), .IF_CLEAR(IF_CLEAR));

// *** sim/xf_dispatch_model.sv ***
// Dispatch model that acknowledges exception requests after a chosen delay.
`timescale 1ns/1ps
module xf_dispatch_model
(
  input  wire logic       clock,   // Core clock
  input  wire logic       rst,     // Reset
  input  wire logic       exc_req, // Request from the unit
  input  wire logic [1:0] dly,     // Wait before answering
  input  wire logic       gate_in, // Entry kind to report
  output logic            exc_ack, // Acknowledge
  output logic            gate     // Gate kind
);
  logic [1:0] cnt_ff;
  // Outside an acknowledge the gate line shows the inverse, never a stale value.
  assign gate = exc_ack ? gate_in : ~gate_in;
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cnt_ff  <= 2'h0;
      exc_ack <= 1'b0;
    end
    else if (!exc_req || exc_ack)
    begin
      cnt_ff  <= 2'h0;
      exc_ack <= 1'b0;
    end
    else if (cnt_ff == dly)
    begin
      exc_ack <= 1'b1;
    end
    else
    begin
      cnt_ff <= cnt_ff + 2'h1;
    end
  end
endmodule

// *** sim/simd_fp_exception_unit_tb_top.sv ***
// Self-checking testbench of the SIMD floating-point exception unit.
`timescale 1ns/1ps
module simd_fp_exception_unit_tb_top
  import simd_fp_exc_pkg::*;
;
  logic         clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, iv = 0, ip = 0;
  logic         pready, pslverr, ir, rv, daz, ftz, ieee, req, fault, ack, gate, ifc, irq;
  logic         gin = 0, seen = 0, ce = 1;
  logic [1:0]   dly = 0;
  logic [11:0]  paddr = 0;
  logic [31:0]  pwdata = 0, prdata, lf = 32'h23CD;
  logic [23:0]  ef = 0;
  logic [127:0] rin = 0, rout;
  logic [7:0]   vec;
  logic [5:0]   cause, mask_m = 6'h3F, flag_m = 6'h00, f6;
  logic [32:0]  rdq[$];
  logic [135:0] iq[$];
  int           n_mismatch = 0, compares = 0, cyc = 0;

  simd_fp_exception_unit dut (.CLOCK(clock), .RST(rst), .CE(ce), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .INSTR_VALID(iv), .INSTR_READY(ir),
    .INSTR_PACKED(ip), .ELEM_FLAGS(ef), .RESULT_IN(rin), .RESULT_OUT(rout),
    .RESULT_VALID(rv), .DAZ_MODE(daz), .FTZ_MODE(ftz), .IEEE_STRICT(ieee), .EXC_REQ(req),
    .EXC_VECTOR(vec), .EXC_FAULT(fault), .EXC_CAUSE(cause), .EXC_ACK(ack),
    .GATE_INTR(gate), .IF_CLEAR(ifc), .IRQ(irq));
  xf_dispatch_model disp (.clock(clock), .rst(rst), .exc_req(req), .dly(dly),
    .gate_in(gin), .exc_ack(ack), .gate(gate));

  initial
  begin
    forever #2.5 clock = ~clock;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic summarize();
    if (n_mismatch == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input bit ok, input string m);
    compares++;
    if (!ok)
    begin
      n_mismatch++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err);
    rdq.push_back({err, e});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wcs(input logic [1:0] md);
    apb(1'b1, ADDR_CTRL_STATUS, {14'h0, md, 2'h0, mask_m, 2'h0, flag_m});
  endtask

  task automatic ins(input logic p, input logic [23:0] f);
    logic [5:0] m;
    logic [5:0] u;
    m = p ? f[5:0] | f[11:6] | f[17:12] | f[23:18] : f[5:0];
    u = m & ~mask_m;
    lf = lfsr(lf);
    if ((u & PRE_CLASSES) != 6'h0)
      iq.push_back({2'b11, u & PRE_CLASSES, 128'h0});
    else
      iq.push_back((u != 6'h0) ? {2'b10, u, 128'h0} : {8'h00, {4{lf}}});
    flag_m = flag_m | (((u & PRE_CLASSES) != 6'h0) ? (m & PRE_CLASSES) : m);
    @(posedge clock);
    iv <= 1'b1;
    ip <= p;
    ef <= f;
    rin <= {4{lf}};
    do @(posedge clock); while (ir !== 1'b1);
    iv <= 1'b0;
  endtask

  always @(posedge clock)
  begin
    if (psel && penable && pready && !pwrite)
      chk(rdq.size() > 0 && rdq.pop_front() === {pslverr, prdata}, "read data");
    if (rv === 1'b1)
      chk(iq.size() > 0 && iq.pop_front() === {8'h00, rout}, "result");
    if (req === 1'b1 && !seen)
      chk(iq.size() > 0 && iq.pop_front() === {1'b1, fault, cause, 128'h0}, "exc");
    seen = (req === 1'b1);
    cyc++;
    if (cyc > 20000)
    begin
      n_mismatch++;
      summarize();
    end
  end

  initial
  begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rd(ADDR_CTRL_STATUS, {18'h0, RST_MASK, 2'h0, RST_FLAGS}, 1'b0);
    rd(ADDR_INT_STATUS, 32'h0, 1'b0);
    rd(12'h010, 32'h0, 1'b1);
    apb(1'b1, ADDR_INT_MASK, 32'h7);
    ce <= 1'b0;
    apb(1'b1, ADDR_INT_MASK, 32'h0);
    ce <= 1'b1;
    rd(ADDR_INT_MASK, 32'h7, 1'b0);
    ins(1'b1, 24'h020000 | 24'h000200);
    ins(1'b0, 24'h001000);
    rd(ADDR_CTRL_STATUS, {18'h0, mask_m, 2'h0, flag_m}, 1'b0);
    rd(ADDR_INT_STATUS, 32'h4, 1'b0);
    apb(1'b1, ADDR_INT_STATUS, 32'h7);
    @(negedge clock);
    chk(irq === 1'b0, "irq clear");
    mask_m = 6'h37;
    wcs(2'h0);
    ins(1'b0, 24'h0);
    for (int c = 0; c < NUM_CLASS; c++)
    begin
      lf = lfsr(lf);
      dly <= lf[4:3];
      gin <= lf[5];
      mask_m = ~(6'h01 << c);
      wcs(2'h0);
      f6 = 6'h01 << c;
      ins(lf[0], 24'(f6) << (lf[0] ? 6 * lf[2:1] : 0));
    end
    rd(ADDR_CTRL_STATUS, {18'h0, mask_m, 2'h0, flag_m}, 1'b0);
    rd(ADDR_INT_STATUS, 32'h3, 1'b0);
    chk(irq === 1'b1, "irq set");
    mask_m = 6'h00;
    flag_m = 6'h00;
    wcs(2'h0);
    ins(1'b1, 24'h000001 | 24'h008000);
    rd(ADDR_UNIT_STATE, 32'h0001_0101, 1'b0);
    rd(ADDR_CTRL_STATUS, {18'h0, mask_m, 2'h0, flag_m}, 1'b0);
    for (int k = 0; k < 4; k++)
    begin
      wcs(k[1:0]);
      @(negedge clock);
      chk(daz === k[0] && ftz === k[1] && ieee === (k == 0), "modes");
    end
    repeat (20) @(posedge clock);
    chk(iq.size() == 0 && rdq.size() == 0, "missing outcome");
    summarize();
  end
endmodule
